// >>> core/serial_channel_pkg.sv
// constants for the serial channel data word and status register bank
package serial_channel_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses on the apb bus)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W     = 20;
  localparam logic [19:0] STATUS_OFS = 20'hf0100;
  localparam logic [19:0] CLEAR_OFS  = 20'hf0108;
  localparam logic [19:0] DATA_OFS   = 20'hf0110;
  localparam logic [19:0] CTRL_OFS   = 20'hf0120;
  localparam logic [19:0] TRIG_OFS   = 20'hf0124;
  // ----------------------------------------------------------------
  // data word layout
  // ----------------------------------------------------------------
  localparam int unsigned BUF_W   = 8;
  localparam int unsigned DIV_W   = 7;
  localparam int unsigned DIV_LSB = 9;
  localparam int unsigned DIV_MSB = 15;
  localparam int unsigned CNT_W   = 8;
  // ----------------------------------------------------------------
  // status, clear, control and trigger bit positions
  // ----------------------------------------------------------------
  localparam int unsigned TSF_BIT  = 6;
  localparam int unsigned BFF_BIT  = 5;
  localparam int unsigned FEF_BIT  = 2;
  localparam int unsigned PEF_BIT  = 1;
  localparam int unsigned OVF_BIT  = 0;
  localparam int unsigned FECT_BIT = 2;
  localparam int unsigned PECT_BIT = 1;
  localparam int unsigned OVCT_BIT = 0;
  localparam int unsigned TXE_BIT  = 0;
  localparam int unsigned RXE_BIT  = 1;
  localparam int unsigned CCS_BIT  = 2;
  localparam int unsigned RUN_BIT  = 3;
  localparam int unsigned STA_BIT  = 0;
  localparam int unsigned STP_BIT  = 1;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] DATA_RST   = 16'h0000;
  localparam logic [15:0] STATUS_RST = 16'h0000;
endpackage

// >>> core/serial_channel_data_status.sv
// data word, divider and status flags of one serial channel, apb slave
module serial_channel_data_status (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [19:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_comm_start,
  input  wire logic        i_comm_end,
  input  wire logic        i_rx_store,
  input  wire logic [7:0]  i_rx_data,
  input  wire logic        i_tx_load,
  input  wire logic        i_rx_no_stop,
  input  wire logic        i_rx_parity_bad,
  input  wire logic        i_i2c_no_ack,
  input  wire logic        i_slave_tx_late,
  output logic      [7:0]  o_tx_data,
  output logic             o_xfer_tick,
  output logic             o_running,
  output logic             o_tx_enable,
  output logic             o_rx_enable,
  output logic             o_clock_source
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        pready_ff;
  logic        nxt_pready;
  logic        slverr_ff;
  logic        nxt_slverr;
  logic [7:0]  buf_ff;
  logic [7:0]  nxt_buf;
  logic [6:0]  div_ff;
  logic [6:0]  nxt_div;
  logic        txe_ff;
  logic        nxt_txe;
  logic        rxe_ff;
  logic        nxt_rxe;
  logic        ccs_ff;
  logic        nxt_ccs;
  logic        run_ff;
  logic        nxt_run;
  logic        tsf_ff;
  logic        nxt_tsf;
  logic        bff_ff;
  logic        nxt_bff;
  logic        fef_ff;
  logic        nxt_fef;
  logic        pef_ff;
  logic        nxt_pef;
  logic        ovf_ff;
  logic        nxt_ovf;
  logic [7:0]  cnt_ff;
  logic [7:0]  nxt_cnt;
  logic        tick_ff;
  logic        nxt_tick;
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic        setup;
  logic        wr;
  logic        rd;
  logic        hit_status;
  logic        hit_clear;
  logic        hit_data;
  logic        hit_ctrl;
  logic        hit_trig;
  logic        buf_wr;
  logic        start;
  logic        stop;
  logic        clr_fe;
  logic        clr_pe;
  logic        clr_ov;
  logic        rx_err;
  logic        set_bff;
  logic        clr_bff;
  logic        div_en;
  logic [15:0] status_word;
  logic [15:0] data_word;
  logic [7:0]  term;

  always_comb begin
    setup      = i_psel & ~i_penable;
    wr         = i_psel & i_penable & pready_ff & i_pwrite;
    rd         = i_psel & i_penable & pready_ff & ~i_pwrite;
    hit_status = (i_paddr == serial_channel_pkg::STATUS_OFS);
    hit_clear  = (i_paddr == serial_channel_pkg::CLEAR_OFS);
    hit_data   = (i_paddr == serial_channel_pkg::DATA_OFS);
    hit_ctrl   = (i_paddr == serial_channel_pkg::CTRL_OFS);
    hit_trig   = (i_paddr == serial_channel_pkg::TRIG_OFS);
    buf_wr     = wr & hit_data & i_pstrb[0];
    start      = wr & hit_trig & i_pstrb[0] & i_pwdata[serial_channel_pkg::STA_BIT];
    stop       = wr & hit_trig & i_pstrb[0] & i_pwdata[serial_channel_pkg::STP_BIT];
    // clear triggers are never stored, so they act for one cycle only
    clr_fe     = wr & hit_clear & i_pstrb[0] & i_pwdata[serial_channel_pkg::FECT_BIT];
    clr_pe     = wr & hit_clear & i_pstrb[0] & i_pwdata[serial_channel_pkg::PECT_BIT];
    clr_ov     = wr & hit_clear & i_pstrb[0] & i_pwdata[serial_channel_pkg::OVCT_BIT];
    rx_err     = i_rx_no_stop | i_rx_parity_bad;
    status_word = serial_channel_pkg::STATUS_RST;
    status_word[serial_channel_pkg::TSF_BIT] = tsf_ff;
    status_word[serial_channel_pkg::BFF_BIT] = bff_ff;
    status_word[serial_channel_pkg::FEF_BIT] = fef_ff;
    status_word[serial_channel_pkg::PEF_BIT] = pef_ff;
    status_word[serial_channel_pkg::OVF_BIT] = ovf_ff;
    // bit 8 has no storage and reads zero
    data_word = {div_ff, 1'b0, buf_ff};
    if (run_ff) begin
      data_word[serial_channel_pkg::DIV_MSB:serial_channel_pkg::DIV_LSB] = 7'h00;
    end
  end

  // ----------------------------------------------------------------
  // apb slave: read data captured in setup, one access cycle
  // ----------------------------------------------------------------
  always_comb begin
    nxt_pready = setup;
    nxt_prdata = prdata_ff;
    nxt_slverr = 1'b0;
    if (setup) begin
      nxt_prdata = 32'h0000_0000;
      if (hit_status) begin
        nxt_prdata[15:0] = status_word;
      end else if (hit_data) begin
        nxt_prdata[15:0] = data_word;
      end else if (hit_clear || hit_trig) begin
        nxt_prdata = 32'h0000_0000;
      end else if (hit_ctrl) begin
        nxt_prdata[serial_channel_pkg::TXE_BIT] = txe_ff;
        nxt_prdata[serial_channel_pkg::RXE_BIT] = rxe_ff;
        nxt_prdata[serial_channel_pkg::CCS_BIT] = ccs_ff;
        nxt_prdata[serial_channel_pkg::RUN_BIT] = run_ff;
      end else begin
        nxt_slverr = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      slverr_ff <= 1'b0;
    end else begin
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      slverr_ff <= nxt_slverr;
    end
  end

  // ----------------------------------------------------------------
  // data word and control
  // ----------------------------------------------------------------
  always_comb begin
    nxt_buf = buf_ff;
    nxt_div = div_ff;
    nxt_txe = txe_ff;
    nxt_rxe = rxe_ff;
    nxt_ccs = ccs_ff;
    nxt_run = run_ff;
    if (i_rx_store) begin
      nxt_buf = i_rx_data;
    end
    // a bus write replaces held data, so a colliding store is lost
    if (buf_wr) begin
      nxt_buf = i_pwdata[7:0];
    end
    if (wr && hit_data && !run_ff) begin
      if (i_pstrb[1]) begin
        nxt_div = i_pwdata[serial_channel_pkg::DIV_MSB:serial_channel_pkg::DIV_LSB];
      end else if (i_pstrb[0]) begin
        nxt_div = 7'h00;
      end
    end
    if (wr && hit_ctrl && i_pstrb[0]) begin
      nxt_txe = i_pwdata[serial_channel_pkg::TXE_BIT];
      nxt_rxe = i_pwdata[serial_channel_pkg::RXE_BIT];
      nxt_ccs = i_pwdata[serial_channel_pkg::CCS_BIT];
    end
    if (start) begin
      nxt_run = 1'b1;
    end else if (stop) begin
      nxt_run = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      buf_ff <= serial_channel_pkg::DATA_RST[7:0];
      div_ff <= serial_channel_pkg::DATA_RST[15:9];
      txe_ff <= 1'b0;
      rxe_ff <= 1'b0;
      ccs_ff <= 1'b0;
      run_ff <= 1'b0;
    end else begin
      buf_ff <= nxt_buf;
      div_ff <= nxt_div;
      txe_ff <= nxt_txe;
      rxe_ff <= nxt_rxe;
      ccs_ff <= nxt_ccs;
      run_ff <= nxt_run;
    end
  end

  // ----------------------------------------------------------------
  // status flags: a set in the clearing cycle wins
  // ----------------------------------------------------------------
  always_comb begin
    set_bff = (buf_wr & txe_ff) | (i_rx_store & rxe_ff) | rx_err;
    clr_bff = i_tx_load | (rd & hit_data & rxe_ff) | start | stop;
    nxt_tsf = tsf_ff;
    if (i_comm_end || start || stop) begin
      nxt_tsf = 1'b0;
    end
    if (i_comm_start) begin
      nxt_tsf = 1'b1;
    end
    nxt_bff = (bff_ff & ~clr_bff) | set_bff;
    nxt_fef = (fef_ff & ~clr_fe) | i_rx_no_stop;
    nxt_pef = (pef_ff & ~clr_pe) | i_rx_parity_bad | i_i2c_no_ack;
    nxt_ovf = (ovf_ff & ~clr_ov)
            | (buf_wr & bff_ff)
            | (i_rx_store & rxe_ff & bff_ff) | i_slave_tx_late;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      tsf_ff <= serial_channel_pkg::STATUS_RST[serial_channel_pkg::TSF_BIT];
      bff_ff <= serial_channel_pkg::STATUS_RST[serial_channel_pkg::BFF_BIT];
      fef_ff <= serial_channel_pkg::STATUS_RST[serial_channel_pkg::FEF_BIT];
      pef_ff <= serial_channel_pkg::STATUS_RST[serial_channel_pkg::PEF_BIT];
      ovf_ff <= serial_channel_pkg::STATUS_RST[serial_channel_pkg::OVF_BIT];
    end else begin
      tsf_ff <= nxt_tsf;
      bff_ff <= nxt_bff;
      fef_ff <= nxt_fef;
      pef_ff <= nxt_pef;
      ovf_ff <= nxt_ovf;
    end
  end

  // ----------------------------------------------------------------
  // transfer clock divider
  // ----------------------------------------------------------------
  always_comb begin
    div_en   = run_ff & ~ccs_ff;
    term     = {div_ff, 1'b1};
    nxt_cnt  = 8'h00;
    nxt_tick = 1'b0;
    // counting 0 .. 2n+1 gives one tick per 2*(n+1) clocks
    if (div_en) begin
      if (cnt_ff == term) begin
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cnt_ff  <= 8'h00;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign o_prdata       = prdata_ff;
  assign o_pready       = pready_ff;
  assign o_pslverr      = slverr_ff;
  assign o_tx_data      = buf_ff;
  assign o_xfer_tick    = tick_ff;
  assign o_running      = run_ff;
  assign o_tx_enable    = txe_ff;
  assign o_rx_enable    = rxe_ff;
  assign o_clock_source = ccs_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_tick_div0;
    tick_ff && div_en && (div_ff == 7'h00);
  endsequence

  sequence s_hold_div0;
    div_en && (div_ff == 7'h00);
  endsequence

  chk_tick_period: assert property (
    s_tick_div0 ##1 s_hold_div0 |=> tick_ff
  ) else $error("divide-by-2 tick missing");

  chk_div_hidden: assert property (
    setup && hit_data && run_ff |=> o_prdata[15:9] == 7'h00
  ) else $error("divider visible while running");

  chk_div_hold: assert property (
    wr && hit_data && run_ff |=> div_ff == $past(div_ff)
  ) else $error("divider written while running");

  chk_div_clear: assert property (
    wr && hit_data && !run_ff && i_pstrb[1:0] == 2'b01 |=> div_ff == 7'h00
  ) else $error("low byte write kept divider");

  chk_status_map: assert property (
    setup && hit_status |=> o_prdata == {25'h0, $past(tsf_ff), $past(bff_ff),
                                         2'b00, $past(fef_ff), $past(pef_ff), $past(ovf_ff)}
  ) else $error("status word layout wrong");

  chk_clear_zero: assert property (
    setup && hit_clear |=> o_prdata == 32'h0000_0000
  ) else $error("clear register read not zero");

  chk_ovf_full: assert property (
    buf_wr && bff_ff |=> ovf_ff
  ) else $error("overrun missed on write while full");

  chk_ovf_sticky: assert property (
    ovf_ff && !clr_ov |=> ovf_ff
  ) else $error("overrun dropped without trigger");

  chk_bff_trig: assert property (
    (start || stop) && !set_bff |=> !bff_ff
  ) else $error("full flag survived trigger");

  chk_tsf_start: assert property (
    i_comm_start |=> tsf_ff ##1 (tsf_ff || $past(i_comm_end || start || stop))
  ) else $error("active flag not set on start");

  chk_rx_store: assert property (
    i_rx_store && !buf_wr |=> o_tx_data == $past(i_rx_data)
  ) else $error("received byte not stored");

  chk_nack_pef: assert property (
    i_i2c_no_ack |=> pef_ff
  ) else $error("missing ack not flagged");

  chk_fef_set: assert property (
    i_rx_no_stop |=> fef_ff && bff_ff
  ) else $error("framing error not flagged");

  chk_reset_clear: assert property (
    @(posedge i_sys_clk) disable iff (1'b0)
    !i_rst_n |=> data_word == 16'h0000 && status_word == 16'h0000
  ) else $error("reset left state set");
endmodule

// >>> testbench/line_peer.sv
// behavioural shift engine and serial peer that raises line events on command
module line_peer (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_go,
  input  wire logic [2:0] i_kind,
  input  wire logic [7:0] i_byte,
  output logic            o_comm_start,
  output logic            o_comm_end,
  output logic            o_rx_store,
  output logic            o_tx_load,
  output logic            o_rx_no_stop,
  output logic            o_rx_parity_bad,
  output logic            o_i2c_no_ack,
  output logic            o_slave_tx_late,
  output logic      [7:0] o_rx_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ev_ff;
  // ----------------------------------------------------------------
  // one-cycle event pulses
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ev_ff <= 8'h00;
      o_rx_data <= 8'h00;
    end else begin
      ev_ff <= i_go ? (8'h01 << i_kind) : 8'h00;
      // data lines toggle outside a store so a stale byte never looks valid
      o_rx_data <= (i_go && i_kind == 3'h2) ? i_byte : ~o_rx_data;
    end
  end
  assign o_comm_start    = ev_ff[0];
  assign o_comm_end      = ev_ff[1];
  assign o_rx_store      = ev_ff[2];
  assign o_tx_load       = ev_ff[3];
  assign o_rx_no_stop    = ev_ff[4];
  assign o_rx_parity_bad = ev_ff[5];
  assign o_i2c_no_ack    = ev_ff[6];
  assign o_slave_tx_late = ev_ff[7];
endmodule

// >>> testbench/tb_top.sv
// self-checking bench for the serial channel data word and status bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [19:0] paddr   = 20'h00000;
  logic [31:0] pwdata  = 32'h00000000;
  logic [3:0]  pstrb   = 4'h0;
  logic        go      = 1'b0;
  logic [2:0]  kind    = 3'h0;
  logic [7:0]  byt     = 8'h00;
  logic [31:0] prdata, r;
  logic [7:0]  txd, rxd, b;
  logic [6:0]  d;
  logic        pready, pslverr, err, tick, run, txe, rxe, csel;
  logic        cs, ce, st_ev, ld, nstop, pbad, nack, late;
  int          fail_count, tests_run, seed, i, k, g, pos;

  serial_channel_data_status serial_channel_data_status_inst (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_comm_start(cs), .i_comm_end(ce), .i_rx_store(st_ev), .i_rx_data(rxd),
    .i_tx_load(ld), .i_rx_no_stop(nstop), .i_rx_parity_bad(pbad), .i_i2c_no_ack(nack),
    .i_slave_tx_late(late), .o_tx_data(txd), .o_xfer_tick(tick), .o_running(run),
    .o_tx_enable(txe), .o_rx_enable(rxe), .o_clock_source(csel));

  line_peer line_peer_inst (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_go(go), .i_kind(kind), .i_byte(byt),
    .o_comm_start(cs), .o_comm_end(ce), .o_rx_store(st_ev), .o_tx_load(ld),
    .o_rx_no_stop(nstop), .o_rx_parity_bad(pbad), .o_i2c_no_ack(nack),
    .o_slave_tx_late(late), .o_rx_data(rxd));

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // bus, event and check tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] wd, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    // ready, read data and error are all taken at the same rising edge
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fail_count++;
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] a);
    apb(1'b0, a, 32'h00000000, 4'h0);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic st();
    rd(serial_channel_pkg::STATUS_OFS);
    chk(r & 32'hffffff98, 32'h00000000);
  endtask
  task automatic ev(input logic [2:0] kd, input logic [7:0] bv);
    @(posedge sys_clk);
    go <= 1'b1;
    kind <= kd;
    byt <= bv;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  // spacing between two transfer ticks, bounded so a silent divider fails
  task automatic tick_gap(output int gap);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (tick !== 1'b1 && n < 600);
    gap = 0;
    do begin
      @(negedge sys_clk);
      gap++;
    end while (tick !== 1'b1 && gap < 600);
  endtask
  task automatic end_of_test();
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge sys_clk);
    fail_count++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 1;
    fail_count = 0;
    tests_run = 0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    st();
    chk(r, 32'h00000000);
    rd(serial_channel_pkg::DATA_OFS);
    chk(r, 32'h00000000);
    rd(serial_channel_pkg::CLEAR_OFS);
    chk(r, 32'h00000000);
    rd(20'hf0130);
    chk({31'h0, err}, 32'h00000001);
    for (i = 0; i < 2; i++) begin
      d = i ? 7'h7f : 7'(2 + ($random(seed) & 3));
      b = 8'($random(seed));
      apb(1'b1, serial_channel_pkg::DATA_OFS, {16'h0, d, 1'b0, b}, 4'h3);
      rd(serial_channel_pkg::DATA_OFS);
      chk(r, {16'h0, d, 1'b0, b});
      chk({24'h0, txd}, {24'h0, b});
      apb(1'b1, serial_channel_pkg::CTRL_OFS, 32'h00000003, 4'h1);
      apb(1'b1, serial_channel_pkg::TRIG_OFS, 32'h00000001, 4'h1);
      // let the start edge settle before looking at the levels
      @(negedge sys_clk);
      chk({28'h0, run, csel, rxe, txe}, 32'h0000000b);
      tick_gap(g);
      chk(32'(g), 32'(2 * (d + 1)));
      b = 8'($random(seed));
      apb(1'b1, serial_channel_pkg::DATA_OFS, {16'h0, ~d, 1'b0, b}, 4'h3);
      st();
      chk({31'h0, r[5]}, 32'h00000001);
      apb(1'b1, serial_channel_pkg::DATA_OFS, {16'h0, d, 1'b0, ~b}, 4'h3);
      st();
      chk({31'h0, r[0]}, 32'h00000001);
      ev(3'h3, 8'h00);
      st();
      chk(r, 32'h00000001);
      // a data read with receive enabled clears full, so it comes after the flag checks
      rd(serial_channel_pkg::DATA_OFS);
      chk(r, {24'h0, ~b});
      apb(1'b1, serial_channel_pkg::TRIG_OFS, 32'h00000002, 4'h1);
      rd(serial_channel_pkg::DATA_OFS);
      chk({25'h0, r[15:9]}, {25'h0, d});
      apb(1'b1, serial_channel_pkg::CLEAR_OFS, 32'h00000001, 4'h1);
      st();
      chk(r, 32'h00000000);
    end
    apb(1'b1, serial_channel_pkg::DATA_OFS, 32'h000000a5, 4'h1);
    rd(serial_channel_pkg::DATA_OFS);
    chk(r, 32'h000000a5);
    apb(1'b1, serial_channel_pkg::TRIG_OFS, 32'h00000001, 4'h1);
    ev(3'h0, 8'h00);
    st();
    chk(r, 32'h00000040);
    ev(3'h1, 8'h00);
    st();
    chk(r, 32'h00000000);
    ev(3'h0, 8'h00);
    apb(1'b1, serial_channel_pkg::TRIG_OFS, 32'h00000002, 4'h1);
    st();
    chk(r, 32'h00000000);
    apb(1'b1, serial_channel_pkg::TRIG_OFS, 32'h00000001, 4'h1);
    for (k = 4; k < 8; k++) begin
      pos = (k == 4) ? 2 : (k == 7) ? 0 : 1;
      b = 8'($random(seed));
      ev(3'(k), 8'h00);
      st();
      chk({31'h0, r[pos]}, 32'h00000001);
      ev(3'h2, b);
      rd(serial_channel_pkg::DATA_OFS);
      chk({24'h0, r[7:0]}, {24'h0, b});
      st();
      chk({31'h0, r[pos]}, 32'h00000001);
      apb(1'b1, serial_channel_pkg::CLEAR_OFS, 32'h00000007, 4'h1);
      st();
      chk(r & 32'h00000007, 32'h00000000);
    end
    // external clock source: the divider must fall silent although it runs at 0
    apb(1'b1, serial_channel_pkg::CTRL_OFS, 32'h00000007, 4'h1);
    repeat (2) @(posedge sys_clk);
    g = 0;
    repeat (20) begin
      @(negedge sys_clk);
      g += (tick !== 1'b0) ? 1 : 0;
    end
    chk({31'h0, csel}, 32'h00000001);
    chk(32'(g), 32'h00000000);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(serial_channel_pkg::DATA_OFS);
    chk(r, 32'h00000000);
    st();
    chk(r, 32'h00000000);
    end_of_test();
  end
endmodule
